// file: include/cfg_list_pkg.sv
// Constants, types and the summary of operation for the configuration list parser.
// Summary of operation
// - Record list reading begins at EEPROM byte 140.
// - Every record opens with start flag byte 0x01.
// - Flag byte 0x00 ends the list; parsing stops there.
// - Type byte 0x02 at record index 1 marks a serial bridge record.
// - Function ID at index 2: 0x0B first serial port, 0x0C second.
// - Index 3 of a serial bridge record holds the bridge type ID.
// - Type IDs 0x01 to 0x04 decode into the listed port mode pairs.
// - Type byte 0x01 marks a MAC address record.
// - MAC record function ID 0x04 targets MII, 0x05 targets RMII.
// - Bytes at indices 3 to 8 form the six-byte MAC address.
// - Digital I/O stays undriven before and during configuration.
// - After configuration, lines the design does not use stay undriven.
// - Pin listing: one function ID per pin, pin 0 at byte 20.
// - Records are read only within bytes 140 to 253.
package cfg_list_pkg;

	localparam logic [7:0] PIN_BASE = 8'h14;
	localparam int PIN_COUNT = 23;
	localparam logic [4:0] PIN_LAST_IDX = 5'h16;
	localparam logic [7:0] LIST_BASE = 8'h8c;
	localparam logic [7:0] LIST_LAST = 8'hfd;

	localparam logic [7:0] FLAG_START = 8'h01;
	localparam logic [7:0] FLAG_END = 8'h00;
	localparam logic [7:0] TYPE_MAC = 8'h01;
	localparam logic [7:0] TYPE_SPI = 8'h02;
	localparam logic [7:0] FID_MII = 8'h04;
	localparam logic [7:0] FID_RMII = 8'h05;
	localparam logic [7:0] FID_SPI1 = 8'h0b;
	localparam logic [7:0] FID_SPI2 = 8'h0c;
	localparam logic [7:0] TID_232_232 = 8'h01;
	localparam logic [7:0] TID_232_485422 = 8'h02;
	localparam logic [7:0] TID_485422_485422 = 8'h03;
	localparam logic [7:0] TID_485_485 = 8'h04;

	localparam logic [4:0] IDX_FLAG = 5'h00;
	localparam logic [4:0] IDX_TYPE = 5'h01;
	localparam logic [4:0] IDX_FUNC = 5'h02;
	localparam logic [4:0] IDX_DATA = 5'h03;
	localparam logic [4:0] IDX_MAC_LAST = 5'h08;

	// Target slots, also the bit positions of the valid vector.
	localparam logic [1:0] TGT_SPI1 = 2'h0;
	localparam logic [1:0] TGT_SPI2 = 2'h1;
	localparam logic [1:0] TGT_MII = 2'h2;
	localparam logic [1:0] TGT_RMII = 2'h3;

	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_PINS = 4'h2,
		S_RECS = 4'h4,
		S_DONE = 4'h8
	} parser_fsm_type;

	typedef enum logic [1:0] {
		MODE_NONE = 2'h0,
		MODE_RS232 = 2'h1,
		MODE_RS485_422 = 2'h2,
		MODE_RS485 = 2'h3
	} port_mode_type;

	typedef struct packed {
		port_mode_type port1;
		port_mode_type port2;
	} mode_pair_type;

	typedef struct packed {
		parser_fsm_type state;
		logic [7:0] addr;
		logic [4:0] idx;
		logic is_mac;
		logic [1:0] target;
		logic [47:0] mac_acc;
		logic rd_req;
		logic done;
		logic error;
		logic [3:0] valid;
		mode_pair_type spi1_modes;
		mode_pair_type spi2_modes;
		logic [47:0] mii_mac;
		logic [47:0] rmii_mac;
		logic [PIN_COUNT-1:0][7:0] pin_func;
	} parser_state_type;

	typedef struct packed {
		logic out;
		logic oe;
	} dio_pad_type;

endpackage

// file: sim/eeprom_byte_model.sv
// Behavioural model of the card EEPROM answering byte reads of the parser.
`timescale 1ns/10ps
`default_nettype none
module eeprom_byte_model #(
	// The card's bus address; chosen clear of every reserved pattern.
	parameter logic [6:0] BUS_ADDR = 7'h50
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic rd_req,
	input wire logic [7:0] rd_addr,
	output logic rd_valid,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:255];
	logic [1:0] wait_reg;

	// Between answers the data lines toggle so that a stale byte is never mistaken for a fresh one.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
			wait_reg <= 2'h0;
		end
		else if (rd_req && !rd_valid && wait_reg == (slow ? 2'h3 : 2'h0))
		begin
			rd_valid <= 1'b1;
			rd_data <= mem[rd_addr];
			wait_reg <= 2'h0;
		end
		else
		begin
			rd_valid <= 1'b0;
			rd_data <= ~rd_data;
			wait_reg <= (rd_req && !rd_valid) ? wait_reg + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

// file: sim/expansion_card_config_list_parser_test.sv
// Self-checking bench of the configuration list parser against the EEPROM model.
`timescale 1ns/10ps
`default_nettype none
module expansion_card_config_list_parser_test;
	typedef struct {
		logic [7:0] tid1;
		logic [7:0] tid2;
		logic [47:0] mac1;
		logic [47:0] mac2;
	} row_type;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic slow = 1'b0;
	logic [22:0] design_out = 23'h2a5a5a;
	logic [22:0] design_oe = 23'h35c3a6;
	logic rd_req, rd_valid, busy, done, error;
	logic [7:0] rd_addr, rd_data;
	logic [3:0] valid;
	cfg_list_pkg::mode_pair_type spi1_modes, spi2_modes;
	logic [47:0] mii_mac, rmii_mac;
	logic [183:0] pin_func, pin_exp;
	logic [22:0] pad_out, pad_oe;
	int err_total = 0;
	int n_checks = 0;
	int p, exp_addr, i, j;
	row_type rows [4];
	logic [31:0] bad [5];
	// Reserved bus addresses that the card's EEPROM must stay clear of.
	localparam logic [6:0] card_bus_addr = 7'h50;
	localparam logic [5:0] addr_clash = {card_bus_addr[6:3] == 4'h0, card_bus_addr[6:3] == 4'hf,
		card_bus_addr == 7'h08, card_bus_addr == 7'h0c, card_bus_addr == 7'h61, card_bus_addr == 7'h68};

	always #5 ref_clk = ~ref_clk;

	config_list_parser dut_u (.ref_clk(ref_clk), .rst(rst), .start(start), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .done(done),
		.error(error), .valid(valid), .spi1_modes(spi1_modes), .spi2_modes(spi2_modes),
		.mii_mac(mii_mac), .rmii_mac(rmii_mac), .pin_func(pin_func), .design_out(design_out),
		.design_oe(design_oe), .pad_out(pad_out), .pad_oe(pad_oe));
	eeprom_byte_model #(.BUS_ADDR(card_bus_addr)) eeprom_u (.ref_clk(ref_clk), .rst(rst),
		.slow(slow), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
		.rd_data(rd_data));

	task automatic chk(input string nm, input logic [183:0] e, input logic [183:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task summarize;
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic cfg_list_pkg::mode_pair_type modes(input logic [7:0] t);
		case (t)
			8'h01: return {cfg_list_pkg::MODE_RS232, cfg_list_pkg::MODE_RS232};
			8'h02: return {cfg_list_pkg::MODE_RS232, cfg_list_pkg::MODE_RS485_422};
			8'h03: return {cfg_list_pkg::MODE_RS485_422, cfg_list_pkg::MODE_RS485_422};
			default: return {cfg_list_pkg::MODE_RS485, cfg_list_pkg::MODE_RS485};
		endcase
	endfunction

	task automatic put(input logic [7:0] b);
		eeprom_u.mem[p] = b;
		p++;
	endtask

	task automatic spi(input logic [7:0] fid, input logic [7:0] tid);
		put(8'h01);
		put(8'h02);
		put(fid);
		put(tid);
	endtask

	task automatic mac(input logic [7:0] fid, input logic [47:0] m);
		put(8'h01);
		put(8'h01);
		put(fid);
		for (int k = 5; k >= 0; k--)
			put(m[8*k +: 8]);
	endtask

	// Everything past the end flag is filled with junk so a parser that reads on is caught.
	task automatic clr;
		for (int k = 140; k < 256; k++)
			eeprom_u.mem[k] = 8'h5a;
		p = 140;
	endtask

	task automatic run(input logic e_err, input logic [3:0] e_val);
		int k;
		exp_addr = 20;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 3000)
		begin
			chk("pad_oe busy", 184'h0, pad_oe);
			chk("busy", 184'h1, busy);
			@(negedge ref_clk);
			k++;
		end
		chk("done", 184'h1, done);
		chk("error", e_err, error);
		chk("valid", e_val, valid);
		chk("pin_func", pin_exp, pin_func);
		@(negedge ref_clk);
		chk("pad_oe done", design_oe, pad_oe);
		chk("pad_out", design_out, pad_out);
	endtask

	// Every consumed byte must come from the next address of the documented walk.
	always @(posedge ref_clk)
	begin
		if (!rst && rd_req === 1'b1 && rd_valid === 1'b1)
		begin
			chk("rd_addr", exp_addr, rd_addr);
			exp_addr = (exp_addr == 42) ? 140 : exp_addr + 1;
		end
	end

	initial
	begin
		#100000;
		err_total++;
		summarize();
	end

	initial
	begin
		for (i = 0; i < 23; i++)
		begin
			eeprom_u.mem[20 + i] = 8'(20 + i) ^ 8'h33;
			pin_exp[8*i +: 8] = 8'(20 + i) ^ 8'h33;
		end
		rows = '{'{8'h01, 8'h02, 48'h0a1b2c3d4e5f, 48'hf0e1d2c3b4a5},
			'{8'h02, 8'h03, 48'h010203040506, 48'h8899aabbccdd},
			'{8'h03, 8'h04, 48'hfeffff00ff01, 48'h000000000001},
			'{8'h04, 8'h01, 48'h800000000000, 48'h123456789abc}};
		bad = '{32'h02020b01, 32'h01030b01, 32'h01020d01, 32'h01020b05, 32'h01010601};
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		for (i = 0; i < 4; i++)
		begin
			clr();
			slow = (i == 3);
			spi(8'h0b, rows[i].tid1);
			mac(8'h04, rows[i].mac1);
			spi(8'h0c, rows[i].tid2);
			mac(8'h05, rows[i].mac2);
			put(8'h00);
			run(1'b0, 4'hf);
			chk("spi1_modes", modes(rows[i].tid1), spi1_modes);
			chk("spi2_modes", modes(rows[i].tid2), spi2_modes);
			chk("mii_mac", rows[i].mac1, mii_mac);
			chk("rmii_mac", rows[i].mac2, rmii_mac);
		end
		slow = 1'b0;
		clr();
		put(8'h00);
		design_oe = 23'h0;
		run(1'b0, 4'h0);
		design_oe = 23'h35c3a6;
		chk("stop addr", 141, exp_addr);
		for (i = 0; i < 5; i++)
		begin
			clr();
			spi(8'h0b, 8'h01);
			for (j = 3; j >= 0; j--)
				put(bad[i][8*j +: 8]);
			run(1'b1, 4'h1);
		end
		// Records that fill the region to its last byte with and without a closing flag.
		for (i = 0; i < 2; i++)
		begin
			clr();
			for (j = 0; j < 26 - 2*i; j++)
				spi(8'h0c, 8'h02);
			mac(8'h05, 48'h112233445566);
			if (i == 0)
				put(8'h00);
			else
				mac(8'h04, 48'h665544332211);
			run(i[0], i ? 4'he : 4'ha);
			chk("last addr", 254, exp_addr);
		end
		exp_addr = 20;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b1;
		@(negedge ref_clk);
		rst = 1'b0;
		chk("idle after reset", 184'h0, {busy, rd_req, done, error, valid, pad_oe});
		clr();
		put(8'h00);
		run(1'b0, 4'h0);
		chk("bus addr", 184'h0, addr_clash);
		summarize();
	end
endmodule
`default_nettype wire

// file: src/config_list_parser.sv
// Parser for the pin listing and additional configuration list of a card EEPROM.
`timescale 1ns/10ps
`default_nettype none
module config_list_parser #(
	parameter int LINES = 23
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	output logic rd_req,
	output logic [7:0] rd_addr,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic busy,
	output logic done,
	output logic error,
	output logic [3:0] valid,
	output cfg_list_pkg::mode_pair_type spi1_modes,
	output cfg_list_pkg::mode_pair_type spi2_modes,
	output logic [47:0] mii_mac,
	output logic [47:0] rmii_mac,
	output logic [cfg_list_pkg::PIN_COUNT*8-1:0] pin_func,
	input wire logic [LINES-1:0] design_out,
	input wire logic [LINES-1:0] design_oe,
	output logic [LINES-1:0] pad_out,
	output logic [LINES-1:0] pad_oe
);

	cfg_list_pkg::parser_state_type st_reg;
	cfg_list_pkg::parser_state_type st_next;

	function automatic cfg_list_pkg::mode_pair_type decode_modes(input logic [7:0] tid);
		cfg_list_pkg::mode_pair_type m;
		m = '{cfg_list_pkg::MODE_NONE, cfg_list_pkg::MODE_NONE};
		unique case (tid)
			cfg_list_pkg::TID_232_232:
				m = '{cfg_list_pkg::MODE_RS232, cfg_list_pkg::MODE_RS232};
			cfg_list_pkg::TID_232_485422:
				m = '{cfg_list_pkg::MODE_RS232, cfg_list_pkg::MODE_RS485_422};
			cfg_list_pkg::TID_485422_485422:
				m = '{cfg_list_pkg::MODE_RS485_422, cfg_list_pkg::MODE_RS485_422};
			cfg_list_pkg::TID_485_485:
				m = '{cfg_list_pkg::MODE_RS485, cfg_list_pkg::MODE_RS485};
			default:
				m = '{cfg_list_pkg::MODE_NONE, cfg_list_pkg::MODE_NONE};
		endcase
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		logic go;
		logic fail;
		logic fin;
		logic adv;
		logic over;
		cfg_list_pkg::mode_pair_type modes;
		go = start && (st_reg.state == cfg_list_pkg::S_IDLE || st_reg.state == cfg_list_pkg::S_DONE);
		fail = 1'b0;
		fin = 1'b0;
		adv = 1'b0;
		over = 1'b0;
		modes = decode_modes(rd_data);
		st_next = st_reg;
		unique case (st_reg.state)
			cfg_list_pkg::S_IDLE, cfg_list_pkg::S_DONE:
			begin
				if (go)
				begin
					st_next.state = cfg_list_pkg::S_PINS;
					st_next.addr = cfg_list_pkg::PIN_BASE;
					st_next.idx = '0;
					st_next.rd_req = 1'b1;
					st_next.done = 1'b0;
					st_next.error = 1'b0;
					st_next.valid = '0;
				end
			end
			cfg_list_pkg::S_PINS:
			begin
				if (rd_valid)
				begin
					st_next.pin_func[st_reg.idx] = rd_data;
					if (st_reg.idx == cfg_list_pkg::PIN_LAST_IDX)
					begin
						st_next.state = cfg_list_pkg::S_RECS;
						st_next.addr = cfg_list_pkg::LIST_BASE;
						st_next.idx = cfg_list_pkg::IDX_FLAG;
					end
					else
					begin
						st_next.addr = st_reg.addr + 8'h01;
						st_next.idx = st_reg.idx + 5'h01;
					end
				end
			end
			cfg_list_pkg::S_RECS:
			begin
				if (rd_valid)
				begin
					adv = 1'b1;
					st_next.idx = st_reg.idx + 5'h01;
					if (st_reg.idx == cfg_list_pkg::IDX_FLAG)
					begin
						if (rd_data == cfg_list_pkg::FLAG_END)
							fin = 1'b1;
						else if (rd_data != cfg_list_pkg::FLAG_START)
							fail = 1'b1;
					end
					else if (st_reg.idx == cfg_list_pkg::IDX_TYPE)
					begin
						if (rd_data == cfg_list_pkg::TYPE_MAC)
							st_next.is_mac = 1'b1;
						else if (rd_data == cfg_list_pkg::TYPE_SPI)
							st_next.is_mac = 1'b0;
						else
							fail = 1'b1;
					end
					else if (st_reg.idx == cfg_list_pkg::IDX_FUNC)
					begin
						if (st_reg.is_mac && rd_data == cfg_list_pkg::FID_MII)
							st_next.target = cfg_list_pkg::TGT_MII;
						else if (st_reg.is_mac && rd_data == cfg_list_pkg::FID_RMII)
							st_next.target = cfg_list_pkg::TGT_RMII;
						else if (!st_reg.is_mac && rd_data == cfg_list_pkg::FID_SPI1)
							st_next.target = cfg_list_pkg::TGT_SPI1;
						else if (!st_reg.is_mac && rd_data == cfg_list_pkg::FID_SPI2)
							st_next.target = cfg_list_pkg::TGT_SPI2;
						else
							fail = 1'b1;
					end
					else if (!st_reg.is_mac)
					begin
						// A bridge type outside the table is treated as an unknown record.
						if (modes.port1 == cfg_list_pkg::MODE_NONE)
							fail = 1'b1;
						else if (st_reg.target == cfg_list_pkg::TGT_SPI1)
							st_next.spi1_modes = modes;
						else
							st_next.spi2_modes = modes;
						st_next.valid[st_reg.target] = 1'b1;
						st_next.idx = cfg_list_pkg::IDX_FLAG;
					end
					else
					begin
						st_next.mac_acc = {st_reg.mac_acc[39:0], rd_data};
						if (st_reg.idx == cfg_list_pkg::IDX_MAC_LAST)
						begin
							if (st_reg.target == cfg_list_pkg::TGT_MII)
								st_next.mii_mac = {st_reg.mac_acc[39:0], rd_data};
							else
								st_next.rmii_mac = {st_reg.mac_acc[39:0], rd_data};
							st_next.valid[st_reg.target] = 1'b1;
							st_next.idx = cfg_list_pkg::IDX_FLAG;
						end
					end
				end
			end
			default:
				st_next.state = cfg_list_pkg::S_IDLE;
		endcase
		// A list that would run past the region end is malformed.
		// A record that closes on the last byte still counts; only the missing end flag is wrong.
		if (adv && !fail && !fin && st_reg.addr == cfg_list_pkg::LIST_LAST)
			over = 1'b1;
		if (fail || over || fin)
		begin
			st_next.state = cfg_list_pkg::S_DONE;
			st_next.rd_req = 1'b0;
			st_next.done = 1'b1;
			st_next.error = fail || over;
			if (fail)
				st_next.valid = st_reg.valid;
		end
		else if (adv)
			st_next.addr = st_reg.addr + 8'h01;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.state <= cfg_list_pkg::S_IDLE;
		end
		else
			st_reg <= st_next;
	end

	assign rd_req = st_reg.rd_req;
	assign rd_addr = st_reg.addr;
	assign busy = st_reg.rd_req;
	assign done = st_reg.done;
	assign error = st_reg.error;
	assign valid = st_reg.valid;
	assign spi1_modes = st_reg.spi1_modes;
	assign spi2_modes = st_reg.spi2_modes;
	assign mii_mac = st_reg.mii_mac;
	assign rmii_mac = st_reg.rmii_mac;
	assign pin_func = st_reg.pin_func;

	// Lines are released only once parsing of the list has ended, cleanly or on an error. The next state drives the
	// gate so that the lines fall undriven at the very edge that takes a new start.
	dio_tristate_gate #(
		.LINES(LINES)
	) u_gate (
		.ref_clk(ref_clk),
		.rst(rst),
		.released(st_next.state == cfg_list_pkg::S_DONE),
		.design_out(design_out),
		.design_oe(design_oe),
		.pad_out(pad_out),
		.pad_oe(pad_oe)
	);

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	wire in_recs = st_reg.state == cfg_list_pkg::S_RECS;
	wire rec_byte = in_recs && rd_valid;

	a_list_base_addr: assert property (st_reg.state == cfg_list_pkg::S_PINS && rd_valid && st_reg.idx == 5'h16 |=> in_recs && rd_addr == 8'h8c)
		else $error("Record list did not start at byte 140");
	a_pin_base_addr: assert property ($rose(st_reg.state == cfg_list_pkg::S_PINS) |-> rd_addr == 8'h14 && rd_req)
		else $error("Pin listing did not start at byte 20");
	a_bad_flag_err: assert property (rec_byte && st_reg.idx == 5'h00 && rd_data != 8'h00 && rd_data != 8'h01 |=> done && error)
		else $error("Bad record flag not flagged");
	a_end_flag_stop: assert property (rec_byte && st_reg.idx == 5'h00 && rd_data == 8'h00 |=> done && !error && !rd_req [*2])
		else $error("End flag did not stop parsing cleanly");
	a_bad_type_err: assert property (rec_byte && st_reg.idx == 5'h01 && rd_data != 8'h01 && rd_data != 8'h02 |=> error)
		else $error("Unknown record type accepted");
	a_spi_decode: assert property (rec_byte && st_reg.idx == 5'h03 && !st_reg.is_mac && st_reg.target == 2'h0 && rd_data == 8'h03 |=> valid[0] && spi1_modes.port1 == cfg_list_pkg::MODE_RS485_422 && spi1_modes.port2 == cfg_list_pkg::MODE_RS485_422)
		else $error("Serial bridge type decoded wrongly");
	a_spi_func_sel: assert property (rec_byte && st_reg.idx == 5'h02 && !st_reg.is_mac && rd_data == 8'h0c |=> st_reg.target == 2'h1)
		else $error("Second serial port not selected");
	a_mac_func_err: assert property (rec_byte && st_reg.idx == 5'h02 && st_reg.is_mac && rd_data == 8'h0b |=> error)
		else $error("MAC record accepted serial function ID");
	a_mac_capture: assert property (rec_byte && st_reg.idx == 5'h08 && st_reg.is_mac && st_reg.target == 2'h2 |=> valid[2] && mii_mac[7:0] == $past(rd_data) && mii_mac[47:8] == $past(st_reg.mac_acc[39:0]))
		else $error("MII MAC address not captured");
	a_region_bound: assert property (rd_req && in_recs |-> rd_addr >= 8'h8c && rd_addr <= 8'hfd)
		else $error("Read outside record region");
	a_no_end_err: assert property (rec_byte && rd_addr == 8'hfd && !(st_reg.idx == 5'h00 && rd_data == 8'h00) |=> done && error)
		else $error("Region end without end flag not flagged");

	c_clean_end: cover property (rec_byte && st_reg.idx == 5'h00 && rd_data == 8'h00 ##1 done && valid != 4'h0);
	c_spi_record: cover property (rec_byte && st_reg.idx == 5'h03 && !st_reg.is_mac ##1 valid[1]);
	c_rmii_record: cover property (rec_byte && st_reg.idx == 5'h08 ##1 valid[3]);
	c_error_stop: cover property (done && error);

endmodule
`default_nettype wire

// file: src/dio_tristate_gate.sv
// Holds digital I/O lines undriven until configuration is over.
`timescale 1ns/10ps
`default_nettype none
module dio_tristate_gate #(
	parameter int LINES = 23
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic released,
	input wire logic [LINES-1:0] design_out,
	input wire logic [LINES-1:0] design_oe,
	output logic [LINES-1:0] pad_out,
	output logic [LINES-1:0] pad_oe
);

	cfg_list_pkg::dio_pad_type [LINES-1:0] pads_reg;
	cfg_list_pkg::dio_pad_type [LINES-1:0] pads_next;

	always_comb
	begin
		for (int i = 0; i < LINES; i++)
		begin
			pads_next[i].out = design_out[i];
			pads_next[i].oe = released & design_oe[i];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			pads_reg <= '0;
		else
			pads_reg <= pads_next;
	end

	genvar g;
	generate
		for (g = 0; g < LINES; g++)
		begin : g_pad
			assign pad_out[g] = pads_reg[g].out;
			assign pad_oe[g] = pads_reg[g].oe;
		end
	endgenerate

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_dio_hold_cfg: assert property (!released |=> pad_oe == '0)
		else $error("I/O driven while configuration in progress");
	a_dio_unused_off: assert property (released && design_oe == '0 |=> pad_oe == '0)
		else $error("Unused I/O line driven after configuration");

endmodule
`default_nettype wire
